// ===== rtl/sfsr_pkg.sv
/*
 * Package for the serial flash status register set: bit positions,
 * command codes, reset values and the protection mode encodings.
 * Assumes the command decoder outside delivers decoded command pulses.
 */
package sfsr_pkg;
    localparam int          ADDR_BITS      = 25;
    localparam int          BLOCK_SHIFT    = 16;
    // Status byte one.
    localparam int          BIT_BUSY       = 0;
    localparam int          BIT_LATCH      = 1;
    localparam int          BIT_LEVEL_LO   = 2;
    localparam int          BIT_LEVEL_HI   = 5;
    localparam int          BIT_BOTTOM     = 6;
    localparam int          BIT_LOCK_LO    = 7;
    // Status byte two, numbered within the byte.
    localparam int          BIT_ADDR_NOW   = 0;
    localparam int          BIT_FOUR_LANE  = 1;
    localparam int          BIT_PROG_PAUSE = 2;
    localparam int          BIT_SEC_LO     = 3;
    localparam int          BIT_SEC_HI     = 5;
    localparam int          BIT_LOCK_HI    = 6;
    localparam int          BIT_ERASE_PAUSE = 7;
    // Status byte three.
    localparam int          BIT_PROG_FAIL  = 2;
    localparam int          BIT_ERASE_FAIL = 3;
    localparam int          BIT_ADDR_BOOT  = 4;
    localparam int          BIT_DRIVE_LO   = 5;
    localparam int          BIT_DRIVE_HI   = 6;
    localparam int          BIT_PIN_FUNC   = 7;
    // Writable masks per byte; read-only and reserved bits never take write data.
    localparam logic [7:0]  WMASK_ONE      = 8'hfc;
    localparam logic [7:0]  WMASK_TWO      = 8'h7a;
    localparam logic [7:0]  WMASK_THREE    = 8'hf0;
    localparam logic [7:0]  RESET_ONE      = 8'h00;
    localparam logic [7:0]  RESET_TWO      = 8'h00;
    localparam logic [7:0]  RESET_THREE    = 8'h20;
    localparam logic [1:0]  DRIVE_FULL     = 2'h0;
    localparam logic [1:0]  DRIVE_3Q       = 2'h1;
    // Protection modes, {sr_lock_hi, sr_lock_lo}.
    localparam logic [1:0]  LOCK_SOFT      = 2'h0;
    localparam logic [1:0]  LOCK_PIN       = 2'h1;
    localparam logic [1:0]  LOCK_POWER     = 2'h2;
    localparam logic [1:0]  LOCK_FOREVER   = 2'h3;
    localparam logic [7:0]  CMD_SUSPEND    = 8'h75;
    localparam logic [7:0]  CMD_RESUME     = 8'h7a;
    localparam logic [7:0]  CMD_CLEAR_FLAG = 8'h30;
    typedef enum logic [1:0] { SFSR_OP_PROG, SFSR_OP_ERASE, SFSR_OP_STATUS } sfsr_op_type;
endpackage : sfsr_pkg

// ===== rtl/sfsr_protect_decode.sv
/*
 * Protected-region decoder: maps protect_level and protect_from_bottom to a
 * hit flag for a target address and an any-protected flag.
 * Assumes 64 KB blocks and a 512-block array.
 */
module sfsr_protect_decode
    import sfsr_pkg::*;
#(
    parameter int ABITS = ADDR_BITS
) (
    input  wire logic [3:0]       level,
    input  wire logic             fromBottom,
    input  wire logic [ABITS-1:0] addr,
    output logic                  hit,
    output logic                  anyProtected
);
    localparam int NBLK = ABITS - BLOCK_SHIFT;
    logic [NBLK-1:0] blk;
    logic [NBLK-1:0] span;
    logic            all;

    always_comb begin
        blk  = addr[ABITS-1:BLOCK_SHIFT];
        // Levels 1..9 protect 2^(level-1) blocks; 10 and above cover the array.
        all  = (level[3] & level[2]) | (level[3] & level[1]);
        span = '0;
        if (level != 4'h0 && level <= 4'ha) begin
            span = NBLK'(1) << (level - 4'h1);
        end
        anyProtected = (level != 4'h0);
        if (all || level == 4'hb) begin
            hit = (level != 4'hb) || 1'b1;
        end else if (level == 4'h0) begin
            hit = 1'b0;
        end else if (fromBottom) begin
            hit = (blk < span);
        end else begin
            hit = (blk >= NBLK'(~span + NBLK'(1)));
        end
    end
endmodule : sfsr_protect_decode

// ===== rtl/sfsr_status_regs.sv
/*
 * Status and configuration register set of a serial NOR flash.
 * Assumes an outside command decoder delivers one-cycle command strobes with
 * their data byte or target address, and an array engine that reports done
 * and failure. Non-volatile bits reload from the nv inputs on power-up.
 */
module sfsr_status_regs
    import sfsr_pkg::*;
#(
    parameter int ABITS = sfsr_pkg::ADDR_BITS
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             powerUp,
    input  wire logic [7:0]       nvOne,
    input  wire logic [7:0]       nvTwo,
    input  wire logic [7:0]       nvThree,
    input  wire logic             writeArmCmd,
    input  wire logic             writeDisarmCmd,
    input  wire logic             softResetCmd,
    input  wire logic [1:0]       statusWriteSel,
    input  wire logic             statusWriteCmd,
    input  wire logic [7:0]       statusWriteData,
    input  wire logic             pageWriteCmd,
    input  wire logic             sectorClearCmd,
    input  wire logic             blockClearCmd,
    input  wire logic             wholeClearCmd,
    input  wire logic             otpTarget,
    input  wire logic [ABITS-1:0] targetAddr,
    input  wire logic [7:0]       plainCmd,
    input  wire logic             plainCmdValid,
    input  wire logic             enter4ByteCmd,
    input  wire logic             exit4ByteCmd,
    input  wire logic             opDone,
    input  wire logic             opFailed,
    input  wire logic             write_guard_pin,
    output logic [7:0]            statusOne,
    output logic [7:0]            statusTwo,
    output logic [7:0]            statusThree,
    output logic                  opStart,
    output logic [1:0]            opKind,
    output logic                  lanesQuad,
    output logic                  pausePinOn,
    output logic                  hwResetPinOn,
    output logic [1:0]            driveLevel
);
    logic [7:0]  one_r, one_nxt;
    logic [7:0]  two_r, two_nxt;
    logic [7:0]  three_r, three_nxt;
    sfsr_op_type op_r, op_nxt;
    logic        busy_r, busy_nxt;
    logic        start_r, start_nxt;
    logic        quad_r, pause_r, hwrst_r;
    logic [1:0]  drv_r;
    logic        protHit, anyProt;

    sfsr_protect_decode #(.ABITS(ABITS)) u_decode (
        .level        (one_r[BIT_LEVEL_HI:BIT_LEVEL_LO]),
        .fromBottom   (one_r[BIT_BOTTOM]),
        .addr         (targetAddr),
        .hit          (protHit),
        .anyProtected (anyProt)
    );

    logic [1:0] lockMode;
    logic       hwProtected;
    logic       statusWritable;
    logic       progOk, eraseOk, wholeOk;
    logic [7:0] wmask, merged;

    always_comb begin
        lockMode    = {two_r[BIT_LOCK_HI], one_r[BIT_LOCK_LO]};
        hwProtected = (lockMode == LOCK_PIN) && !write_guard_pin;
        statusWritable = one_r[BIT_LATCH] && !busy_r;
        case (lockMode)
            LOCK_SOFT:    statusWritable = statusWritable;
            LOCK_PIN:     statusWritable = statusWritable && write_guard_pin;
            LOCK_POWER:   statusWritable = 1'b0;
            LOCK_FOREVER: statusWritable = 1'b0;
            default:      statusWritable = 1'b0;
        endcase
        progOk  = one_r[BIT_LATCH] && !busy_r && !protHit && !otpTarget;
        eraseOk = one_r[BIT_LATCH] && !busy_r && !protHit && !otpTarget;
        wholeOk = one_r[BIT_LATCH] && !busy_r && !anyProt;
    end

    always_comb begin
        one_nxt   = one_r;
        two_nxt   = two_r;
        three_nxt = three_r;
        busy_nxt  = busy_r;
        op_nxt    = op_r;
        start_nxt = 1'b0;
        wmask  = 8'h00;
        merged = 8'h00;
        if (writeArmCmd && !busy_r) begin
            one_nxt[BIT_LATCH] = 1'b1;
        end
        if (writeDisarmCmd) begin
            one_nxt[BIT_LATCH] = 1'b0;
        end
        // The clear sits ahead of every setter, so a failure in the same cycle survives.
        if (plainCmdValid && plainCmd == CMD_CLEAR_FLAG) begin
            three_nxt[BIT_PROG_FAIL]  = 1'b0;
            three_nxt[BIT_ERASE_FAIL] = 1'b0;
        end
        if (statusWriteCmd && statusWritable) begin
            // Only writable bits merge in; read-only flags keep their state.
            case (statusWriteSel)
                2'h0: begin
                    wmask = WMASK_ONE;
                    if (hwProtected) begin
                        wmask = 8'h80;
                    end
                    merged = (one_r & ~wmask) | (statusWriteData & wmask);
                    one_nxt = {merged[7:2], one_nxt[1:0]};
                end
                2'h1: begin
                    wmask  = WMASK_TWO;
                    merged = (two_r & ~wmask) | (statusWriteData & wmask);
                    merged[BIT_SEC_HI:BIT_SEC_LO] = merged[BIT_SEC_HI:BIT_SEC_LO]
                        | two_r[BIT_SEC_HI:BIT_SEC_LO];
                    two_nxt = merged;
                end
                default: begin
                    wmask  = WMASK_THREE;
                    merged = (three_r & ~wmask) | (statusWriteData & wmask);
                    three_nxt = merged;
                end
            endcase
            one_nxt[BIT_LATCH] = 1'b0;
            busy_nxt  = 1'b1;
            op_nxt    = SFSR_OP_STATUS;
            start_nxt = 1'b1;
        end else if (pageWriteCmd && one_r[BIT_LATCH] && !busy_r) begin
            if (progOk) begin
                busy_nxt  = 1'b1;
                op_nxt    = SFSR_OP_PROG;
                start_nxt = 1'b1;
            end else begin
                three_nxt[BIT_PROG_FAIL] = 1'b1;
            end
            one_nxt[BIT_LATCH] = 1'b0;
        end else if ((sectorClearCmd || blockClearCmd || wholeClearCmd) && one_r[BIT_LATCH] && !busy_r) begin
            if ((wholeClearCmd && wholeOk) || (!wholeClearCmd && eraseOk)) begin
                busy_nxt  = 1'b1;
                op_nxt    = SFSR_OP_ERASE;
                start_nxt = 1'b1;
            end else begin
                three_nxt[BIT_ERASE_FAIL] = 1'b1;
            end
            one_nxt[BIT_LATCH] = 1'b0;
        end
        if (plainCmdValid && plainCmd == CMD_SUSPEND && busy_r && op_r != SFSR_OP_STATUS) begin
            two_nxt[BIT_ERASE_PAUSE] = (op_r == SFSR_OP_ERASE) | two_r[BIT_ERASE_PAUSE];
            two_nxt[BIT_PROG_PAUSE]  = (op_r == SFSR_OP_PROG) | two_r[BIT_PROG_PAUSE];
            busy_nxt = 1'b0;
        end
        if (plainCmdValid && plainCmd == CMD_RESUME
            && (two_r[BIT_ERASE_PAUSE] || two_r[BIT_PROG_PAUSE])) begin
            two_nxt[BIT_ERASE_PAUSE] = 1'b0;
            two_nxt[BIT_PROG_PAUSE]  = 1'b0;
            busy_nxt = 1'b1;
        end
        if (enter4ByteCmd) begin
            two_nxt[BIT_ADDR_NOW] = 1'b1;
        end
        if (exit4ByteCmd) begin
            two_nxt[BIT_ADDR_NOW] = 1'b0;
        end
        // Failure report wins over a clear arriving in the same cycle.
        if (opDone && busy_r) begin
            busy_nxt = 1'b0;
            if (opFailed && op_r == SFSR_OP_PROG) begin
                three_nxt[BIT_PROG_FAIL] = 1'b1;
            end
            if (opFailed && op_r == SFSR_OP_ERASE) begin
                three_nxt[BIT_ERASE_FAIL] = 1'b1;
            end
        end
        if (softResetCmd) begin
            one_nxt[BIT_LATCH]       = 1'b0;
            two_nxt[BIT_ERASE_PAUSE] = 1'b0;
            two_nxt[BIT_PROG_PAUSE]  = 1'b0;
            two_nxt[BIT_ADDR_NOW]    = three_r[BIT_ADDR_BOOT];
        end
        one_nxt[BIT_BUSY] = busy_nxt;
        // A power-supply lock survives only until the next power cycle.
        if (powerUp) begin
            one_nxt   = (nvOne & WMASK_ONE) | RESET_ONE;
            two_nxt   = (nvTwo & WMASK_TWO) | RESET_TWO;
            three_nxt = nvThree & WMASK_THREE;
            two_nxt[BIT_ADDR_NOW] = nvThree[BIT_ADDR_BOOT];
            if ({nvTwo[BIT_LOCK_HI], nvOne[BIT_LOCK_LO]} == LOCK_POWER) begin
                one_nxt[BIT_LOCK_LO] = 1'b0;
                two_nxt[BIT_LOCK_HI] = 1'b0;
            end
            busy_nxt  = 1'b0;
            start_nxt = 1'b0;
            one_nxt[BIT_BUSY] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            one_r   <= RESET_ONE;
            two_r   <= RESET_TWO;
            three_r <= RESET_THREE;
            busy_r  <= 1'b0;
            op_r    <= SFSR_OP_PROG;
            start_r <= 1'b0;
            quad_r  <= 1'b0;
            pause_r <= 1'b1;
            hwrst_r <= 1'b0;
            drv_r   <= DRIVE_3Q;
        end else begin
            one_r   <= one_nxt;
            two_r   <= two_nxt;
            three_r <= three_nxt;
            busy_r  <= busy_nxt;
            op_r    <= op_nxt;
            start_r <= start_nxt;
            quad_r  <= two_nxt[BIT_FOUR_LANE];
            pause_r <= !two_nxt[BIT_FOUR_LANE] && !three_nxt[BIT_PIN_FUNC];
            hwrst_r <= !two_nxt[BIT_FOUR_LANE] && three_nxt[BIT_PIN_FUNC];
            drv_r   <= three_nxt[BIT_DRIVE_HI:BIT_DRIVE_LO];
        end
    end

    always_comb begin
        statusOne    = one_r;
        statusTwo    = two_r;
        statusThree  = three_r;
        opStart      = start_r;
        opKind       = op_r;
        lanesQuad    = quad_r;
        pausePinOn   = pause_r;
        hwResetPinOn = hwrst_r;
        driveLevel   = drv_r;
    end

    AST_BUSY_FOLLOWS_START: assert property (@(posedge ref_clk) disable iff (!resetn)
        opStart |-> statusOne[BIT_BUSY]) else $error("busy not set with start");
    AST_NO_START_UNARMED: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pageWriteCmd && !one_r[BIT_LATCH] && !powerUp) |=> !opStart) else $error("unarmed program started");
    AST_PROTECT_REJECT: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pageWriteCmd && protHit && !powerUp) |=> !opStart) else $error("protected program started");
    AST_WHOLE_REJECT: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wholeClearCmd && anyProt && !powerUp && !pageWriteCmd && !statusWriteCmd) |=> !opStart)
        else $error("whole clear ran on protected array");
    AST_LOCK_FOREVER: assert property (@(posedge ref_clk) disable iff (!resetn)
        (lockMode == LOCK_FOREVER && !powerUp) |=> $stable(one_r[7:2])) else $error("locked byte changed");
    AST_SECURE_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn)
        (two_r[BIT_SEC_HI:BIT_SEC_LO] != 3'h0 && !powerUp) |=> two_r[BIT_SEC_HI:BIT_SEC_LO] != 3'h0)
        else $error("security lock cleared");
    AST_CLEAR_FAIL: assert property (@(posedge ref_clk) disable iff (!resetn)
        (plainCmdValid && plainCmd == CMD_CLEAR_FLAG && !busy_r && !pageWriteCmd && !sectorClearCmd
         && !blockClearCmd && !wholeClearCmd && !powerUp) |=> !three_r[BIT_PROG_FAIL] && !three_r[BIT_ERASE_FAIL])
        else $error("fail flags not cleared");
    AST_PIN_FUNC: assert property (@(posedge ref_clk) disable iff (!resetn)
        lanesQuad |-> !pausePinOn && !hwResetPinOn) else $error("pin function active in four-lane mode");
    AST_BUSY_CLEARS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (opDone && busy_r && !powerUp && !(plainCmdValid && plainCmd == CMD_RESUME)) |=> !statusOne[BIT_BUSY])
        else $error("busy stayed after done");
    AST_STATUS_REFUSED: assert property (@(posedge ref_clk) disable iff (!resetn)
        (statusWriteCmd && !one_r[BIT_LATCH] && !powerUp) |=> $stable(one_r[7:2]) && !opStart)
        else $error("unarmed status write took effect");
    AST_LOCK_PIN: assert property (@(posedge ref_clk) disable iff (!resetn)
        (statusWriteCmd && lockMode == LOCK_PIN && !write_guard_pin && !powerUp) |=> $stable(one_r[7:2]))
        else $error("status write passed with guard pin low");
    AST_PAUSE_CLEARED: assert property (@(posedge ref_clk) disable iff (!resetn)
        (softResetCmd && !powerUp) |=> !two_r[BIT_ERASE_PAUSE] && !two_r[BIT_PROG_PAUSE])
        else $error("paused flag survived software reset");
    AST_FAIL_ON_OTP: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pageWriteCmd && otpTarget && one_r[BIT_LATCH] && !busy_r && !statusWriteCmd && !powerUp)
        |=> three_r[BIT_PROG_FAIL] && !opStart) else $error("locked area program not flagged");
    AST_ADDR_BOOT: assert property (@(posedge ref_clk) disable iff (!resetn)
        powerUp |=> statusTwo[BIT_ADDR_NOW] == $past(nvThree[BIT_ADDR_BOOT])) else $error("boot address width wrong");
    AST_LATCH_CLEARED: assert property (@(posedge ref_clk) disable iff (!resetn)
        (statusWriteCmd && statusWritable && !powerUp) |=> !one_r[BIT_LATCH])
        else $error("write latch kept after status write");
endmodule : sfsr_status_regs

// ===== test/sfsr_array_model.sv
/*
 * Array engine model facing the status register set: answers each operation
 * start with a one-cycle done pulse, promptly or after a long program time.
 * Assumes one operation at a time and a fail request set up by the bench.
 */
module sfsr_array_model (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic opStart,
    input  wire logic slow,
    input  wire logic failNext,
    output logic      opDone,
    output logic      opFailed
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_r;
    // Outside the done pulse the fail line carries the wrong answer, so a design
    // that samples it at the wrong moment is caught.
    assign opFailed = opDone ? failNext : ~failNext;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r  <= 0;
            opDone <= 1'b0;
        end else begin
            opDone <= (cnt_r == 1);
            if (opStart) begin
                cnt_r <= slow ? 150 : 3;
            end else if (cnt_r > 0) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule : sfsr_array_model

// ===== test/serial_flash_status_regs_test.sv
/*
 * Self-checking bench for the status register set: scenario tasks drive the
 * decoded command strobes and judge the status bytes and pin controls.
 * Assumes the array engine model answers every operation start.
 */
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module serial_flash_status_regs_test;
    import sfsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 ref_clk, resetn, powerUp, guardPin, slow, failNext;
    logic [7:0]           nvOne, nvTwo, nvThree, statusWriteData, plainCmd;
    logic                 writeArmCmd, writeDisarmCmd, softResetCmd, statusWriteCmd, plainCmdValid;
    logic                 pageWriteCmd, sectorClearCmd, blockClearCmd, wholeClearCmd, otpTarget;
    logic                 enter4ByteCmd, exit4ByteCmd;
    logic [1:0]           statusWriteSel;
    logic [ADDR_BITS-1:0] targetAddr;
    wire logic            opDone, opFailed, opStart, lanesQuad, pausePinOn, hwResetPinOn;
    wire logic [7:0]      statusOne, statusTwo, statusThree;
    wire logic [1:0]      opKind, driveLevel;
    int                   n_fail, cmp_count;

    sfsr_status_regs dut (.ref_clk(ref_clk), .resetn(resetn), .powerUp(powerUp), .nvOne(nvOne),
        .nvTwo(nvTwo), .nvThree(nvThree), .writeArmCmd(writeArmCmd), .writeDisarmCmd(writeDisarmCmd),
        .softResetCmd(softResetCmd), .statusWriteSel(statusWriteSel), .statusWriteCmd(statusWriteCmd),
        .statusWriteData(statusWriteData), .pageWriteCmd(pageWriteCmd), .sectorClearCmd(sectorClearCmd),
        .blockClearCmd(blockClearCmd), .wholeClearCmd(wholeClearCmd), .otpTarget(otpTarget),
        .targetAddr(targetAddr), .plainCmd(plainCmd), .plainCmdValid(plainCmdValid),
        .enter4ByteCmd(enter4ByteCmd), .exit4ByteCmd(exit4ByteCmd), .opDone(opDone), .opFailed(opFailed),
        .write_guard_pin(guardPin), .statusOne(statusOne), .statusTwo(statusTwo),
        .statusThree(statusThree), .opStart(opStart), .opKind(opKind), .lanesQuad(lanesQuad),
        .pausePinOn(pausePinOn), .hwResetPinOn(hwResetPinOn), .driveLevel(driveLevel));
    sfsr_array_model partner (.ref_clk(ref_clk), .resetn(resetn), .opStart(opStart), .slow(slow),
        .failNext(failNext), .opDone(opDone), .opFailed(opFailed));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // One strobe for one cycle; a quiet cycle follows so no strobe is set and
    // cleared in the same time step. On return the taking edge has been seen.
    task automatic issue(input int c, input logic [1:0] sel, input logic [7:0] d,
                         input logic [ADDR_BITS-1:0] a);
        @(posedge ref_clk);
        #1;
        statusWriteSel  = sel;
        statusWriteData = d;
        plainCmd        = d;
        targetAddr      = a;
        case (c)
            0: writeArmCmd = 1'b1;
            1: writeDisarmCmd = 1'b1;
            2: softResetCmd = 1'b1;
            3: statusWriteCmd = 1'b1;
            4: pageWriteCmd = 1'b1;
            5: sectorClearCmd = 1'b1;
            6: blockClearCmd = 1'b1;
            7: wholeClearCmd = 1'b1;
            8: plainCmdValid = 1'b1;
            9: enter4ByteCmd = 1'b1;
            10: exit4ByteCmd = 1'b1;
            default: powerUp = 1'b1;
        endcase
        @(posedge ref_clk);
        #1;
        {writeArmCmd, writeDisarmCmd, softResetCmd, statusWriteCmd, pageWriteCmd, sectorClearCmd,
         blockClearCmd, wholeClearCmd, plainCmdValid, enter4ByteCmd, exit4ByteCmd, powerUp} = '0;
    endtask : issue

    task automatic arm_write(input logic [1:0] sel, input logic [7:0] d);
        issue(0, 2'h0, 8'h00, '0);
        issue(3, sel, d, '0);
    endtask : arm_write

    task automatic wait_idle;
        int i;
        for (i = 0; i < 400 && statusOne[BIT_BUSY] !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 400) begin
            n_fail++;
            wrap_up();
        end
    endtask : wait_idle

    task automatic t_reset;
        `CHK({statusOne, statusTwo, statusThree}, {RESET_ONE, RESET_TWO, RESET_THREE})
        `CHK(driveLevel, DRIVE_3Q)
        `CHK({lanesQuad, pausePinOn, hwResetPinOn}, 3'b010)
        issue(11, 2'h0, 8'h00, '0);
        issue(3, 2'h0, 8'h04, '0);
        `CHK({statusOne, opStart}, 9'h000)
        issue(0, 2'h0, 8'h00, '0);
        `CHK(statusOne[BIT_LATCH], 1'b1)
        issue(1, 2'h0, 8'h00, '0);
        `CHK(statusOne[BIT_LATCH], 1'b0)
        issue(4, 2'h0, 8'h00, '0);
        `CHK({opStart, statusThree[BIT_PROG_FAIL]}, 2'h0)
    endtask : t_reset

    task automatic t_write_one;
        arm_write(2'h0, 8'h07);
        `CHK(statusOne, 8'h05)
        `CHK({opStart, opKind}, {1'b1, SFSR_OP_STATUS})
        wait_idle();
        `CHK(statusOne, 8'h04)
    endtask : t_write_one

    task automatic t_protect;
        for (int c = 4; c < 7; c++) begin
            issue(0, 2'h0, 8'h00, '0);
            issue(c, 2'h0, 8'h00, 25'h1ff8000);
            `CHK({opStart, statusOne[BIT_LATCH]}, 2'b00)
            `CHK(statusThree[3:2], (c == 4) ? 2'b01 : 2'b10)
            issue(8, 2'h0, CMD_CLEAR_FLAG, '0);
            `CHK(statusThree[3:2], 2'b00)
        end
        otpTarget = 1'b1;
        issue(0, 2'h0, 8'h00, '0);
        issue(4, 2'h0, 8'h00, '0);
        `CHK({opStart, statusThree[3:2]}, 3'h1)
        issue(8, 2'h0, CMD_CLEAR_FLAG, '0);
        issue(0, 2'h0, 8'h00, '0);
        issue(5, 2'h0, 8'h00, '0);
        otpTarget = 1'b0;
        `CHK({opStart, statusThree[3:2]}, 3'h2)
        issue(8, 2'h0, CMD_CLEAR_FLAG, '0);
        issue(0, 2'h0, 8'h00, '0);
        issue(7, 2'h0, 8'h00, '0);
        `CHK(opStart, 1'b0)
        failNext = 1'b1;
        issue(0, 2'h0, 8'h00, '0);
        issue(4, 2'h0, 8'h00, '0);
        `CHK({opStart, opKind}, {1'b1, SFSR_OP_PROG})
        wait_idle();
        failNext = 1'b0;
        `CHK(statusThree[BIT_PROG_FAIL], 1'b1)
        issue(8, 2'h0, CMD_CLEAR_FLAG, '0);
    endtask : t_protect

    task automatic t_bottom;
        arm_write(2'h0, 8'h44);
        wait_idle();
        issue(0, 2'h0, 8'h00, '0);
        issue(4, 2'h0, 8'h00, 25'h0000100);
        `CHK({opStart, statusThree[BIT_PROG_FAIL]}, 2'b01)
        issue(8, 2'h0, CMD_CLEAR_FLAG, '0);
        issue(0, 2'h0, 8'h00, '0);
        issue(4, 2'h0, 8'h00, 25'h1ff0000);
        `CHK(opStart, 1'b1)
        wait_idle();
    endtask : t_bottom

    task automatic t_lock_pin;
        arm_write(2'h0, 8'h84);
        wait_idle();
        guardPin = 1'b0;
        arm_write(2'h0, 8'h00);
        `CHK({statusOne[7:2], opStart}, 7'h42)
        guardPin = 1'b1;
        arm_write(2'h0, 8'h00);
        wait_idle();
        `CHK(statusOne, 8'h00)
    endtask : t_lock_pin

    task automatic t_lock_power;
        arm_write(2'h1, 8'h40);
        wait_idle();
        arm_write(2'h0, 8'h04);
        `CHK(statusOne[7:2], 6'h00)
        // The stored image carries the lock, so only the power cycle can drop it.
        nvTwo = 8'h40;
        issue(11, 2'h0, 8'h00, '0);
        `CHK(statusTwo[BIT_LOCK_HI], 1'b0)
        nvTwo = RESET_TWO;
    endtask : t_lock_power

    task automatic t_pins;
        failNext = 1'b1;
        issue(0, 2'h0, 8'h00, '0);
        issue(7, 2'h0, 8'h00, '0);
        `CHK({opStart, opKind}, {1'b1, SFSR_OP_ERASE})
        wait_idle();
        failNext = 1'b0;
        `CHK(statusThree[3:2], 2'h2)
        issue(8, 2'h0, CMD_CLEAR_FLAG, '0);
        arm_write(2'h2, 8'h80);
        wait_idle();
        `CHK({lanesQuad, pausePinOn, hwResetPinOn}, 3'b001)
        `CHK(driveLevel, DRIVE_FULL)
        arm_write(2'h1, 8'h0a);
        wait_idle();
        `CHK({lanesQuad, pausePinOn, hwResetPinOn}, 3'b100)
        arm_write(2'h1, 8'h00);
        wait_idle();
        `CHK({statusTwo, lanesQuad}, 9'h010)
    endtask : t_pins

    task automatic t_suspend;
        slow = 1'b1;
        issue(0, 2'h0, 8'h00, '0);
        issue(5, 2'h0, 8'h00, '0);
        issue(8, 2'h0, CMD_SUSPEND, '0);
        `CHK({statusTwo[BIT_ERASE_PAUSE], statusOne[BIT_BUSY]}, 2'b10)
        issue(8, 2'h0, CMD_RESUME, '0);
        `CHK({statusTwo[BIT_ERASE_PAUSE], statusOne[BIT_BUSY]}, 2'b01)
        wait_idle();
        issue(0, 2'h0, 8'h00, '0);
        issue(4, 2'h0, 8'h00, '0);
        issue(8, 2'h0, CMD_SUSPEND, '0);
        `CHK(statusTwo[BIT_PROG_PAUSE], 1'b1)
        issue(2, 2'h0, 8'h00, '0);
        `CHK({statusTwo[BIT_PROG_PAUSE], statusOne[BIT_LATCH]}, 2'b00)
        slow = 1'b0;
        repeat (160) @(posedge ref_clk);
        #1;
    endtask : t_suspend

    task automatic t_addr;
        issue(9, 2'h0, 8'h00, '0);
        `CHK(statusTwo[BIT_ADDR_NOW], 1'b1)
        issue(10, 2'h0, 8'h00, '0);
        `CHK(statusTwo[BIT_ADDR_NOW], 1'b0)
        nvTwo   = 8'h08;
        nvThree = 8'h30;
        issue(11, 2'h0, 8'h00, '0);
        `CHK({statusTwo, statusThree}, 16'h0930)
    endtask : t_addr

    task automatic t_lock_forever;
        arm_write(2'h0, 8'h80);
        wait_idle();
        arm_write(2'h1, 8'h48);
        wait_idle();
        arm_write(2'h0, 8'h04);
        `CHK({statusOne[7:2], statusTwo[BIT_LOCK_HI], opStart}, 8'h82)
    endtask : t_lock_forever

    initial begin
        {powerUp, writeArmCmd, writeDisarmCmd, softResetCmd, statusWriteCmd, pageWriteCmd, sectorClearCmd,
         blockClearCmd, wholeClearCmd, plainCmdValid, enter4ByteCmd, exit4ByteCmd, otpTarget, slow, failNext} = '0;
        {statusWriteSel, statusWriteData, plainCmd, targetAddr} = '0;
        {nvOne, nvTwo, nvThree} = {RESET_ONE, RESET_TWO, RESET_THREE};
        guardPin = 1'b1;
        resetn   = 1'b0;
        n_fail   = 0;
        cmp_count = 0;
        repeat (16) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_write_one();
        t_protect();
        t_bottom();
        t_lock_pin();
        t_lock_power();
        t_pins();
        t_suspend();
        t_addr();
        t_lock_forever();
        wrap_up();
    end
endmodule : serial_flash_status_regs_test
